// file: dv/clk_sel_checker.sv
`timescale 1ns/10ps
module clk_sel_checker
	import clk_gen_pkg::*;
#(
	parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYCLES_DEF
) (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic [19:0] sfr_addr,
	input wire logic        sfr_wr,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_wdata,
	input wire logic [7:0]  sfr_rdata_q,
	input wire logic        pll_power_on,
	input wire logic        stop_release,
	input wire logic        low_osc_ready,
	input wire logic        main_osc_enable_q,
	input wire logic        fast_internal_osc_enable_q,
	input wire logic        cpu_hold_q,
	input wire logic        cpu_clk_tick_q,
	input wire logic        cpu_clock_source_flag,
	input wire logic        main_clock_source_flag
);
	int hold_len_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// length of the current wakeup hold
	always_ff @(posedge sys_clk) begin
		if (!nrst || !cpu_hold_q)
			hold_len_q <= 0;
		else
			hold_len_q <= hold_len_q + 1;
	end
	a_read_flags: assert property (sfr_rd && sfr_addr == SYS_CTRL_ADDR |=>
		sfr_rdata_q[7] == $past(cpu_clock_source_flag)
		&& sfr_rdata_q[5] == $past(main_clock_source_flag)) else $error("flag readback wrong");
	a_hold_start: assert property (stop_release && !cpu_clock_source_flag
		&& main_clock_source_flag |=> cpu_hold_q) else $error("no hold after wakeup");
	a_hold_no_tick: assert property (cpu_hold_q && $past(cpu_hold_q)
		|-> !cpu_clk_tick_q) else $error("cpu ticks during hold");
	// edges need at least two cycles each, so 256 cycles is a safe floor
	a_hold_span: assert property ($fell(cpu_hold_q) |-> hold_len_q >=
		256 + (pll_power_on ? PLL_LOCK_CYCLES : 0)) else $error("hold too short");
	a_main_flag_rise: assert property ($rose(main_clock_source_flag)
		|-> main_osc_enable_q && $past(main_osc_enable_q, 4)) else $error("main flag early");
	a_cpu_flag_rise: assert property ($rose(cpu_clock_source_flag)
		|-> $past(low_osc_ready, 4)) else $error("cpu flag early");
	a_fast_halt: assert property (sfr_wr && sfr_addr == RUN_CTRL_ADDR && sfr_wdata[0]
		|-> ##[1:2] !fast_internal_osc_enable_q) else $error("fast osc not halted");
	a_low_tick: assert property (cpu_clock_source_flag && $past(cpu_clock_source_flag, 2)
		&& !cpu_hold_q |-> cpu_clk_tick_q) else $error("low-speed tick missing");
endmodule
bind clock_select_and_stabilization clk_sel_checker #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) chk (.*);

// file: dv/osc_model.sv
`timescale 1ns/10ps
module osc_model (
	input  wire logic sys_clk,
	input  wire logic main_osc_enable_q,
	input  wire logic fast_internal_osc_enable_q,
	output logic      crystal_oscillator,
	output logic      fast_osc_ready,
	output logic      low_osc_ready
);
	int age;
	initial begin
		crystal_oscillator = 1'b0;
		age = 0;
	end
	// low-speed source runs free from power-up
	assign low_osc_ready = 1'b1;
	// fast source ready only while its enable is high
	assign fast_osc_ready = fast_internal_osc_enable_q;
	// crystal stands still while halted, starts late, 16 ns period
	always @(posedge sys_clk) begin
		if (!main_osc_enable_q) begin
			age <= 0;
			crystal_oscillator <= 1'b0;
		end else begin
			age <= age + 1;
			if (age >= 20 && age[0])
				crystal_oscillator <= ~crystal_oscillator;
		end
	end
endmodule

// file: dv/tb.sv
`timescale 1ns/10ps
module tb;
	import clk_gen_pkg::*;
	localparam int LOCK = 8;
	logic        sys_clk;
	logic        nrst;
	logic [19:0] sfr_addr;
	logic        sfr_wr;
	logic        sfr_rd;
	logic [7:0]  sfr_wdata;
	logic [7:0]  sfr_rdata_q;
	logic        external_main_clock_mode;
	logic        crystal_mode_select;
	logic        pll_power_on;
	logic        stop_exec;
	logic        stop_release;
	logic        crystal_oscillator;
	logic        fast_osc_ready;
	logic        low_osc_ready;
	logic        main_osc_enable_q;
	logic        fast_internal_osc_enable_q;
	logic        sub_clock_input_enable_q;
	logic        cpu_hold_q;
	logic        cpu_clk_tick_q;
	logic        cpu_clock_source_flag;
	logic        main_clock_source_flag;
	int          err_total;
	int          checks_done;
	int          n;

	clock_select_and_stabilization #(.PLL_LOCK_CYCLES(LOCK)) dut (.*);
	osc_model far (.*);

	always #2 sys_clk = ~sys_clk;

	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("Error at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge sys_clk);
		sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [19:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge sys_clk);
		d = sfr_rdata_q;
		sfr_rd = 1'b0;
	endtask
	task automatic rc(input logic [19:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		cmp(16'(d), 16'(e));
	endtask
	// polling bounded; a stuck field ends the run
	task automatic poll(input logic [19:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] d;
		int k;
		k = 0;
		d = ~e;
		while ((d & m) !== e && k < 3000) begin
			rd(a, d);
			k++;
		end
		cmp(16'(d & m), 16'(e));
		if (k >= 3000)
			close_out();
	endtask
	task automatic tick_gap(input int e);
		int k;
		k = 0;
		while (cpu_clk_tick_q !== 1'b1 && k < 100) begin
			@(negedge sys_clk);
			k++;
		end
		k = 0;
		do begin
			@(negedge sys_clk);
			k++;
		end while (cpu_clk_tick_q !== 1'b1 && k < 100);
		cmp(16'(k), 16'(e));
	endtask

	initial begin
		sys_clk = 1'b0;
		nrst = 1'b0;
		sfr_addr = 20'h00000;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
		external_main_clock_mode = 1'b0;
		crystal_mode_select = 1'b1;
		pll_power_on = 1'b0;
		stop_exec = 1'b0;
		stop_release = 1'b0;
		err_total = 0;
		checks_done = 0;
		repeat (3) @(negedge sys_clk);
		nrst = 1'b1;
		rc(STAB_STATUS_ADDR, 8'h00);
		rc(STAB_SELECT_ADDR, 8'h07);
		rc(SYS_CTRL_ADDR, 8'h01);
		rc(RUN_CTRL_ADDR, 8'hc0);
		cmp(16'(sub_clock_input_enable_q), 16'h0000);
		rc(20'hfffa5, 8'h00);
		wr(STAB_SELECT_ADDR, 8'hf9);
		rc(STAB_SELECT_ADDR, 8'h01);
		wr(STAB_STATUS_ADDR, 8'hff);
		rc(STAB_STATUS_ADDR, 8'h00);
		wr(SYS_CTRL_ADDR, 8'ha9);
		rc(SYS_CTRL_ADDR, 8'h01);
		for (int c = 0; c < 6; c++) begin
			wr(SYS_CTRL_ADDR, 8'(c));
			tick_gap(1 << c);
		end
		// fast oscillator may only halt while it feeds nothing: run on low-speed
		wr(SYS_CTRL_ADDR, 8'h41);
		poll(SYS_CTRL_ADDR, 8'hff, 8'hc1);
		wr(RUN_CTRL_ADDR, 8'hc1);
		repeat (2) @(negedge sys_clk);
		cmp(16'(fast_internal_osc_enable_q), 16'h0000);
		wr(RUN_CTRL_ADDR, 8'hc0);
		repeat (2) @(negedge sys_clk);
		cmp(16'(fast_internal_osc_enable_q), 16'h0001);
		wr(SYS_CTRL_ADDR, 8'h01);
		poll(SYS_CTRL_ADDR, 8'hff, 8'h01);
		// halt cleared outside crystal pin mode: nothing may be counted
		crystal_mode_select = 1'b0;
		wr(RUN_CTRL_ADDR, 8'h00);
		repeat (1200) @(negedge sys_clk);
		rc(STAB_STATUS_ADDR, 8'h00);
		cmp(16'(sub_clock_input_enable_q), 16'h0001);
		crystal_mode_select = 1'b1;
		wr(RUN_CTRL_ADDR, 8'hc0);
		// crystal start with the two-to-the-nine wait selected
		wr(RUN_CTRL_ADDR, 8'h40);
		poll(STAB_STATUS_ADDR, 8'h80, 8'h80);
		rc(STAB_STATUS_ADDR, 8'h80);
		poll(STAB_STATUS_ADDR, 8'hff, 8'hc0);
		repeat (3000) @(negedge sys_clk);
		rc(STAB_STATUS_ADDR, 8'hc0);
		wr(SYS_CTRL_ADDR, 8'h11);
		poll(SYS_CTRL_ADDR, 8'hff, 8'h31);
		wr(RUN_CTRL_ADDR, 8'h41);
		repeat (2) @(negedge sys_clk);
		cmp(16'(fast_internal_osc_enable_q), 16'h0000);
		wr(SYS_CTRL_ADDR, 8'h51);
		poll(SYS_CTRL_ADDR, 8'hff, 8'hf1);
		tick_gap(1);
		wr(RUN_CTRL_ADDR, 8'hc1);
		rc(STAB_STATUS_ADDR, 8'h00);
		wr(RUN_CTRL_ADDR, 8'h40);
		poll(STAB_STATUS_ADDR, 8'hff, 8'hc0);
		wr(SYS_CTRL_ADDR, 8'h11);
		poll(SYS_CTRL_ADDR, 8'hff, 8'h31);
		// stop and wake with the crystal feeding the cpu through the pll
		pll_power_on = 1'b1;
		@(negedge sys_clk);
		stop_exec = 1'b1;
		@(negedge sys_clk);
		stop_exec = 1'b0;
		rc(STAB_STATUS_ADDR, 8'h00);
		@(negedge sys_clk);
		stop_release = 1'b1;
		@(negedge sys_clk);
		stop_release = 1'b0;
		cmp(16'(cpu_hold_q), 16'h0001);
		n = 0;
		while (cpu_hold_q === 1'b1 && n < 8000) begin
			@(negedge sys_clk);
			n++;
		end
		cmp(16'(n >= 512 * 4 + LOCK && n < 8000), 16'h0001);
		rc(STAB_STATUS_ADDR, 8'hc0);
		// wake on the fast internal clock: no hold, software polls the status
		pll_power_on = 1'b0;
		wr(SYS_CTRL_ADDR, 8'h01);
		poll(SYS_CTRL_ADDR, 8'hff, 8'h01);
		stop_exec = 1'b1;
		@(negedge sys_clk);
		stop_exec = 1'b0;
		@(negedge sys_clk);
		stop_release = 1'b1;
		@(negedge sys_clk);
		stop_release = 1'b0;
		cmp(16'(cpu_hold_q), 16'h0000);
		poll(STAB_STATUS_ADDR, 8'hff, 8'hc0);
		close_out();
	end
endmodule

// file: hw/clock_select_and_stabilization.sv
// How it works
// - fast oscillator halt bit stops that oscillator
// - status clears on reset, stop, main halt
// - count starts on crystal start or wakeup
// - status bits set in order, stay set
// - counting stops at the selected wait
// - only real crystal edges are counted
// - crystal cpu clock holds until wait ends
// - select register resets to seven, three bits
// - codes pick two to eight..nineteen cycles
// - pll cpu clock adds lock-up wait
// - system control register resets to one
// - bit six picks pll or low-speed
// - bit four picks fast internal or crystal
// - flags report the clocks really in use
// - divider codes zero..five divide pll clock
// - both source flags are read-only
`timescale 1ns/10ps
module clock_select_and_stabilization
	import clk_gen_pkg::*;
#(
	parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYCLES_DEF
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic [19:0] sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata_q,
	input  wire logic        external_main_clock_mode,
	input  wire logic        crystal_mode_select,
	input  wire logic        pll_power_on,
	input  wire logic        stop_exec,
	input  wire logic        stop_release,
	input  wire logic        crystal_oscillator,
	input  wire logic        fast_osc_ready,
	input  wire logic        low_osc_ready,
	output logic             main_osc_enable_q,
	output logic             fast_internal_osc_enable_q,
	output logic             sub_clock_input_enable_q,
	output logic             cpu_hold_q,
	output logic             cpu_clk_tick_q,
	output logic             cpu_clock_source_flag,
	output logic             main_clock_source_flag
);
	import clk_gen_pkg::*;

	if (PLL_LOCK_CYCLES < 1 || PLL_LOCK_CYCLES >= (1 << PLL_CNT_W)) begin : g_bad_lock
		$error("clock_select_and_stabilization: PLL_LOCK_CYCLES out of range");
	end

	// wait length in crystal cycles for a select code
	function automatic logic [STAB_CNT_W-1:0] stab_limit(input logic [2:0] code);
		stab_limit = STAB_CNT_W'(1) << STAB_SEL_EXP[code];
	endfunction

	// register storage
	logic                  main_osc_halt_q;
	logic                  sub_clock_input_halt_q;
	logic                  fast_internal_osc_halt_q;
	logic [2:0]            stab_time_code_q;
	logic                  cpu_clock_source_select_q;
	logic                  main_clock_source_select_q;
	logic [2:0]            pll_divider_q;
	logic [7:0]            osc_stab_status_q;

	// crystal and ready-pin sampling
	logic [SYNC_STAGES-1:0] xtal_sync_q;
	logic                   xtal_prev_q;
	logic                   xtal_edge;
	logic [SYNC_STAGES-1:0] fast_sync_q;
	logic [SYNC_STAGES-1:0] low_sync_q;
	logic                   fast_ready_s;
	logic                   low_ready_s;

	// stabilization counting
	logic [STAB_CNT_W-1:0] stab_cnt_q;
	logic [STAB_CNT_W-1:0] stab_lim;
	logic                  counting_q;
	logic                  stab_done;
	logic                  stab_clear;
	logic                  stab_start;
	logic [7:0]            stab_reached;

	// stop and wakeup
	logic                  stop_mode_q;
	wake_state_e           wake_state_q;
	logic [PLL_CNT_W-1:0]  pll_cnt_q;

	// divider
	logic [4:0]            div_cnt_q;
	logic [2:0]            div_code;
	logic [4:0]            div_last;

	// write strobes, pin mode and switch targets
	logic                  wr_run;
	logic                  wr_select;
	logic                  wr_sys;
	logic                  crystal_pin_mode;
	logic                  main_target_ok;
	logic                  cpu_target_ok;

	assign wr_run    = sfr_wr && (sfr_addr == RUN_CTRL_ADDR);
	assign wr_select = sfr_wr && (sfr_addr == STAB_SELECT_ADDR);
	assign wr_sys    = sfr_wr && (sfr_addr == SYS_CTRL_ADDR);

	// crystal mode means pin bits 0 and 1; a halt-bit clear counts only in this mode, a stop wakeup counts the pin in any mode
	assign crystal_pin_mode = !external_main_clock_mode && crystal_mode_select;

	// ---------------- pin synchronisers ----------------
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			xtal_sync_q <= '0;
			fast_sync_q <= '0;
			low_sync_q  <= '0;
			xtal_prev_q <= 1'b0;
		end else begin
			xtal_sync_q <= {xtal_sync_q[SYNC_STAGES-2:0], crystal_oscillator};
			fast_sync_q <= {fast_sync_q[SYNC_STAGES-2:0], fast_osc_ready};
			low_sync_q  <= {low_sync_q[SYNC_STAGES-2:0], low_osc_ready};
			xtal_prev_q <= xtal_sync_q[SYNC_STAGES-1];
		end
	end

	// a start-up delay produces no edges, so it never reaches the count
	assign xtal_edge    = xtal_sync_q[SYNC_STAGES-1] && !xtal_prev_q;
	assign fast_ready_s = fast_sync_q[SYNC_STAGES-1];
	assign low_ready_s  = low_sync_q[SYNC_STAGES-1];

	// ---------------- clock_run_control ----------------
	// software owns the guard conditions; hardware obeys the halt bits as written
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			main_osc_halt_q          <= RUN_CTRL_RST[MAIN_HALT_BIT];
			sub_clock_input_halt_q   <= RUN_CTRL_RST[SUB_HALT_BIT];
			fast_internal_osc_halt_q <= RUN_CTRL_RST[FAST_HALT_BIT];
		end else if (wr_run) begin
			main_osc_halt_q          <= sfr_wdata[MAIN_HALT_BIT];
			sub_clock_input_halt_q   <= sfr_wdata[SUB_HALT_BIT];
			fast_internal_osc_halt_q <= sfr_wdata[FAST_HALT_BIT];
		end
	end

	// stop mode halts the main and fast internal oscillators until wakeup
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			stop_mode_q <= 1'b0;
		end else if (stop_release) begin
			stop_mode_q <= 1'b0;
		end else if (stop_exec) begin
			stop_mode_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			main_osc_enable_q          <= 1'b0;
			fast_internal_osc_enable_q <= 1'b1;
			sub_clock_input_enable_q   <= 1'b0;
		end else begin
			main_osc_enable_q          <= !main_osc_halt_q && !stop_mode_q;
			fast_internal_osc_enable_q <= !fast_internal_osc_halt_q && !stop_mode_q;
			sub_clock_input_enable_q   <= !sub_clock_input_halt_q;
		end
	end

	// ---------------- osc_stab_select ----------------
	// no lockout during a count; a mid-count change just moves the end point
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			stab_time_code_q <= STAB_SELECT_RST[STAB_CODE_MSB:0];
		end else if (wr_select) begin
			stab_time_code_q <= sfr_wdata[STAB_CODE_MSB:0];
		end
	end

	// ---------------- stabilization counter ----------------
	assign stab_clear = stop_exec || (wr_run && sfr_wdata[MAIN_HALT_BIT]);
	// crystal start needs pin mode set first; a halt-bit clear otherwise counts nothing
	assign stab_start = (wr_run && main_osc_halt_q && !sfr_wdata[MAIN_HALT_BIT]
		&& crystal_pin_mode) || stop_release;
	assign stab_lim   = stab_limit(stab_time_code_q);
	assign stab_done  = (stab_cnt_q >= stab_lim);

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			counting_q <= 1'b0;
		end else if (stab_clear) begin
			counting_q <= 1'b0;
		end else if (stab_start) begin
			counting_q <= 1'b1;
		end else if (stab_done) begin
			counting_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			stab_cnt_q <= '0;
		end else if (stab_clear || stab_start) begin
			stab_cnt_q <= '0;
		end else if (counting_q && xtal_edge && !stab_done) begin
			stab_cnt_q <= stab_cnt_q + STAB_CNT_W'(1);
		end
	end

	// one threshold compare per status bit, msb is the shortest wait
	for (genvar i = 0; i < 8; i++) begin : g_thresh
		assign stab_reached[7-i] = (stab_cnt_q >= (STAB_CNT_W'(1) << STAB_STAT_EXP[i]));
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			osc_stab_status_q <= STAB_STATUS_RST;
		end else if (stab_clear || stab_start) begin
			osc_stab_status_q <= STAB_STATUS_RST;
		end else begin
			osc_stab_status_q <= osc_stab_status_q | stab_reached;
		end
	end

	// ---------------- system_clock_control ----------------
	// main select is not frozen here; software keeps it still while it must
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cpu_clock_source_select_q  <= SYS_CTRL_RST[CPU_SEL_BIT];
			main_clock_source_select_q <= SYS_CTRL_RST[MAIN_SEL_BIT];
			pll_divider_q              <= SYS_CTRL_RST[DIV_MSB:0];
		end else if (wr_sys) begin
			cpu_clock_source_select_q  <= sfr_wdata[CPU_SEL_BIT];
			main_clock_source_select_q <= sfr_wdata[MAIN_SEL_BIT];
			pll_divider_q              <= sfr_wdata[DIV_MSB:0];
		end
	end

	// switch targets: the new source must actually be running; a cpu switch back to the pll is always allowed
	assign main_target_ok = main_clock_source_select_q ?
		(main_osc_enable_q && osc_stab_status_q[7]) :
		(fast_internal_osc_enable_q && fast_ready_s);
	assign cpu_target_ok  = cpu_clock_source_select_q ? low_ready_s : 1'b1;

	clock_source_switch #(
		.SETTLE     (SWITCH_SETTLE_CYCLES),
		.RESET_FLAG (SYS_CTRL_RST[MAIN_FLAG_BIT])
	) u_main_switch (
		.sys_clk       (sys_clk),
		.nrst          (nrst),
		.select_req    (main_clock_source_select_q),
		.target_ready  (main_target_ok),
		.source_flag_q (main_clock_source_flag)
	);

	clock_source_switch #(
		.SETTLE     (SWITCH_SETTLE_CYCLES),
		.RESET_FLAG (SYS_CTRL_RST[CPU_FLAG_BIT])
	) u_cpu_switch (
		.sys_clk       (sys_clk),
		.nrst          (nrst),
		.select_req    (cpu_clock_source_select_q),
		.target_ready  (cpu_target_ok),
		.source_flag_q (cpu_clock_source_flag)
	);

	// ---------------- wakeup hold ----------------
	// internal fast clock as cpu clock gets no hold; software polls status
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			wake_state_q <= WAKE_IDLE;
		end else begin
			case (wake_state_q)
				WAKE_IDLE: begin
					if (stop_release && !cpu_clock_source_flag
						&& main_clock_source_flag) begin
						wake_state_q <= WAKE_STAB;
					end
				end
				WAKE_STAB: begin
					if (stab_done && pll_power_on) begin
						wake_state_q <= WAKE_PLL;
					end else if (stab_done) begin
						wake_state_q <= WAKE_IDLE;
					end
				end
				WAKE_PLL: begin
					if (pll_cnt_q == PLL_CNT_W'(PLL_LOCK_CYCLES - 1)) begin
						wake_state_q <= WAKE_IDLE;
					end
				end
				default: begin
					wake_state_q <= WAKE_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pll_cnt_q <= '0;
		end else if (wake_state_q == WAKE_PLL) begin
			pll_cnt_q <= pll_cnt_q + PLL_CNT_W'(1);
		end else begin
			pll_cnt_q <= '0;
		end
	end

	// hold also covers the release cycle itself
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cpu_hold_q <= 1'b0;
		end else begin
			cpu_hold_q <= (wake_state_q == WAKE_STAB && !(stab_done && !pll_power_on))
				|| (wake_state_q == WAKE_PLL
				&& pll_cnt_q != PLL_CNT_W'(PLL_LOCK_CYCLES - 1))
				|| (wake_state_q == WAKE_IDLE && stop_release
				&& !cpu_clock_source_flag && main_clock_source_flag);
		end
	end

	// ---------------- pll divider ----------------
	// prohibited codes clamp to the slowest ratio rather than wrap
	assign div_code = (pll_divider_q > DIV_CODE_MAX) ? DIV_CODE_MAX : pll_divider_q;
	assign div_last = 5'((6'h01 << div_code) - 6'h01);

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			div_cnt_q <= 5'h00;
		end else if (cpu_clock_source_flag || div_cnt_q >= div_last) begin
			div_cnt_q <= 5'h00;
		end else begin
			div_cnt_q <= div_cnt_q + 5'h01;
		end
	end

	// low-speed clock passes undivided; stop and hold gate the cpu tick
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cpu_clk_tick_q <= 1'b0;
		end else if (stop_mode_q || cpu_hold_q) begin
			cpu_clk_tick_q <= 1'b0;
		end else if (cpu_clock_source_flag) begin
			cpu_clk_tick_q <= 1'b1;
		end else begin
			cpu_clk_tick_q <= (div_cnt_q >= div_last);
		end
	end

	// ---------------- read port ----------------
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sfr_rdata_q <= 8'h00;
		end else if (sfr_rd) begin
			case (sfr_addr)
				RUN_CTRL_ADDR: begin
					sfr_rdata_q <= {main_osc_halt_q, sub_clock_input_halt_q, 5'h00,
						fast_internal_osc_halt_q};
				end
				STAB_STATUS_ADDR: begin
					sfr_rdata_q <= osc_stab_status_q;
				end
				STAB_SELECT_ADDR: begin
					sfr_rdata_q <= {5'h00, stab_time_code_q};
				end
				SYS_CTRL_ADDR: begin
					sfr_rdata_q <= {cpu_clock_source_flag, cpu_clock_source_select_q,
						main_clock_source_flag, main_clock_source_select_q, 1'b0,
						pll_divider_q};
				end
				default: begin
					sfr_rdata_q <= 8'h00;
				end
			endcase
		end else begin
			sfr_rdata_q <= 8'h00;
		end
	end

endmodule

// file: hw/clock_source_switch.sv
`timescale 1ns/10ps
module clock_source_switch
	import clk_gen_pkg::*;
#(
	parameter int   SETTLE     = SWITCH_SETTLE_CYCLES,
	parameter logic RESET_FLAG = 1'b0
) (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic select_req,
	input  wire logic target_ready,
	output logic      source_flag_q
);
	import clk_gen_pkg::*;

	if (SETTLE < 1 || SETTLE > 255) begin : g_bad_settle
		$error("clock_source_switch: SETTLE out of range");
	end

	logic [7:0] settle_cnt_q;
	logic       pending;

	assign pending = (select_req != source_flag_q) && target_ready;

	// the flag moves only after the new source has run cleanly for a while
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			settle_cnt_q <= 8'h00;
		end else if (!pending) begin
			settle_cnt_q <= 8'h00;
		end else if (settle_cnt_q != 8'(SETTLE)) begin
			settle_cnt_q <= settle_cnt_q + 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			source_flag_q <= RESET_FLAG;
		end else if (pending && settle_cnt_q == 8'(SETTLE)) begin
			source_flag_q <= select_req;
		end
	end

endmodule

// file: shared/clk_gen_pkg.sv
package clk_gen_pkg;

	// register addresses on the sfr port
	localparam logic [19:0] RUN_CTRL_ADDR    = 20'hfffa1;
	localparam logic [19:0] STAB_STATUS_ADDR = 20'hfffa2;
	localparam logic [19:0] STAB_SELECT_ADDR = 20'hfffa3;
	localparam logic [19:0] SYS_CTRL_ADDR    = 20'hfffa4;

	// values after reset
	localparam logic [7:0] RUN_CTRL_RST    = 8'hc0;
	localparam logic [7:0] STAB_STATUS_RST = 8'h00;
	localparam logic [7:0] STAB_SELECT_RST = 8'h07;
	localparam logic [7:0] SYS_CTRL_RST    = 8'h01;

	// clock_run_control fields
	localparam int MAIN_HALT_BIT = 7;
	localparam int SUB_HALT_BIT  = 6;
	localparam int FAST_HALT_BIT = 0;

	// system_clock_control fields
	localparam int CPU_FLAG_BIT  = 7;
	localparam int CPU_SEL_BIT   = 6;
	localparam int MAIN_FLAG_BIT = 5;
	localparam int MAIN_SEL_BIT  = 4;
	localparam int DIV_MSB       = 2;

	// osc_stab_select field
	localparam int STAB_CODE_MSB = 2;

	// largest legal pll divider code
	localparam logic [2:0] DIV_CODE_MAX = 3'h5;

	// wait exponents for codes 0..7, status exponents for bits 7..0
	localparam logic [4:0] STAB_SEL_EXP [8]  = '{5'd8, 5'd9, 5'd10, 5'd11,
		5'd13, 5'd15, 5'd17, 5'd19};
	localparam logic [4:0] STAB_STAT_EXP [8] = '{5'd8, 5'd9, 5'd10, 5'd11,
		5'd13, 5'd15, 5'd17, 5'd18};

	// crystal edge counter, wide enough for the longest wait
	localparam int STAB_CNT_W = 20;

	// cycles a requested source must stay ready before the flag moves
	localparam int SWITCH_SETTLE_CYCLES = 4;

	// pll lock-up wait after the crystal wait, in sys_clk cycles
	localparam int PLL_LOCK_CYCLES_DEF = 1024;
	localparam int PLL_CNT_W           = 16;

	// synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 2;

	typedef enum {
		WAKE_IDLE,
		WAKE_STAB,
		WAKE_PLL
	} wake_state_e;

endpackage
